// ### dv/dbg_host_model.sv
`timescale 1ns/1ps
module dbg_host_model
  import flash_prot_pkg::*;
(
  input wire logic clk,
  input wire logic dbgGrant,
  input wire logic dbgDeny,
  output flashReq_t dbgReq
);
  initial dbgReq = '0;
  // Answer code: 2 granted, 1 denied, 0 ignored.
  // Idle fields carry the inverse so a design that ignores valid is caught.
  task automatic issue(input flashOp_t op, input logic [ROW_W-1:0] row,
      output logic [1:0] ans);
    @(posedge clk);
    dbgReq <= '{1'b1, op, row};
    @(posedge clk);
    dbgReq <= '{1'b0, flashOp_t'(~op), ~row};
    @(posedge clk);
    ans = {dbgGrant, dbgDeny};
  endtask
endmodule // dbg_host_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import flash_prot_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdv;
  logic erv, nvCommit, dbgGrant, dbgDeny, sysGrant;
  logic flashEraseAllDone = 1'b0, debugPortEn, testPortEn;
  nvImage_t nvImage = '{RST_MODE, RST_DEBUG_EN, RST_SECURE, '0, '0};
  nvImage_t nvStore;
  flashReq_t dbgReq, flashCmd;
  flashReq_t sysReq = '0;
  int err_total = 0, n_tests = 0;

  always #2.5 clk = ~clk;

  flash_debug_protection_ctrl i_dut (.clk(clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvImage(nvImage), .nvStore(nvStore), .nvCommit(nvCommit),
    .dbgReq(dbgReq), .dbgGrant(dbgGrant), .dbgDeny(dbgDeny),
    .sysReq(sysReq), .sysGrant(sysGrant), .flashCmd(flashCmd),
    .flashEraseAllDone(flashEraseAllDone), .debugPortEn(debugPortEn),
    .testPortEn(testPortEn));

  dbg_host_model i_host (.clk(clk), .dbgGrant(dbgGrant),
    .dbgDeny(dbgDeny), .dbgReq(dbgReq));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] ad, wd);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No limit of its own: only the watchdog ends a stalled transfer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] ad, wd, input logic e);
    apb(1'b1, ad, wd);
    chk("pslverr", erv, e);
  endtask

  task automatic mode_is(input protMode_t m);
    apb(1'b0, ADDR_STATUS, '0);
    chk("mode", rdv[1:0], m);
  endtask

  task automatic dq(input flashOp_t op, input logic [4:0] row,
      input logic [1:0] exp);
    logic [1:0] a;
    i_host.issue(op, row, a);
    chk("debug answer", a, exp);
  endtask

  // System calls must be granted whatever the protection state.
  task automatic sys(input flashOp_t op, input logic [4:0] row);
    @(posedge clk);
    sysReq <= '{1'b1, op, row};
    @(posedge clk);
    sysReq <= '{1'b0, flashOp_t'(~op), ~row};
    @(posedge clk);
    chk("sys grant", {sysGrant, flashCmd}, {2'b11, op, row});
  endtask

  task automatic full_erase;
    sys(OP_ERASE_ALL, 5'h00);
    @(posedge clk);
    flashEraseAllDone <= 1'b1;
    @(posedge clk);
    flashEraseAllDone <= 1'b0;
  endtask

  task automatic t_open;
    apb(1'b0, ADDR_STATUS, '0);
    chk("status", rdv & ~(32'h1 << ERASED_BIT),
        (32'h1 << LOADED_BIT) | (32'h1 << DBG_EN_BIT));
    chk("ports", {debugPortEn, testPortEn}, 2'b11);
    dq(OP_READ, 5'h1f, 2'd2);
    dq(OP_ERASE_ALL, 5'h00, 2'd2);
    $display("test open done");
  endtask

  task automatic t_rows;
    wr(ADDR_RD_PROT, 32'h0000_0008, 1'b0);
    wr(ADDR_WR_PROT, 32'h0000_0020, 1'b0);
    dq(OP_READ, 5'h03, 2'd1);
    dq(OP_WRITE, 5'h03, 2'd2);
    dq(OP_WRITE, 5'h05, 2'd1);
    dq(OP_ERASE_ROW, 5'h05, 2'd1);
    dq(OP_READ, 5'h05, 2'd2);
    sys(OP_READ, 5'h03);
    sys(OP_WRITE, 5'h05);
    wr(ADDR_RD_PROT, 32'h0, 1'b0);
    wr(ADDR_WR_PROT, 32'h0, 1'b0);
    $display("test rows done");
  endtask

  task automatic t_prot;
    wr(ADDR_CTRL, 32'h0000_0011, 1'b0);
    dq(OP_READ, 5'h00, 2'd1);
    dq(OP_ERASE_ALL, 5'h00, 2'd1);
    wr(ADDR_CTRL, 32'h0000_0010, 1'b1);
    mode_is(MODE_PROTECTED);
    full_erase();
    wr(ADDR_CTRL, 32'h0000_0010, 1'b0);
    mode_is(MODE_OPEN);
    $display("test protected done");
  endtask

  task automatic t_dbg;
    wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
    dq(OP_READ, 5'h00, 2'd1);
    full_erase();
    wr(ADDR_WR_PROT, 32'h0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0010, 1'b0);
    dq(OP_READ, 5'h00, 2'd2);
    $display("test debug enable done");
  endtask

  task automatic t_kill;
    wr(ADDR_CTRL, 32'h0000_0012, 1'b0);
    @(posedge clk);
    chk("stored mode", nvStore.mode, MODE_KILL);
    chk("commit", nvCommit, 1'b1);
    dq(OP_READ, 5'h00, 2'd1);
    dq(OP_ERASE_ALL, 5'h00, 2'd0);
    dq(OP_ERASE_ROW, 5'h01, 2'd0);
    wr(ADDR_CTRL, 32'h0000_0010, 1'b1);
    wr(ADDR_CTRL, 32'h0000_0011, 1'b1);
    mode_is(MODE_KILL);
    sys(OP_READ, 5'h02);
    $display("test kill done");
  endtask

  task automatic t_sec;
    wr(ADDR_CTRL, 32'h0000_0112, 1'b0);
    @(posedge clk);
    chk("ports", {debugPortEn, testPortEn}, 2'b00);
    dq(OP_READ, 5'h00, 2'd0);
    wr(ADDR_CTRL, 32'h0000_0012, 1'b0);
    apb(1'b0, ADDR_STATUS, '0);
    chk("secure", rdv[SECURE_BIT], 1'b1);
    $display("test security done");
  endtask

  // The stored image, not the reset values, must rule after a reset.
  task automatic t_nv;
    @(posedge clk);
    nvImage <= '{MODE_PROTECTED, 1'b1, 1'b0, 32'h1, 32'h0};
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    mode_is(MODE_PROTECTED);
    apb(1'b0, ADDR_RD_PROT, '0);
    chk("row prot", rdv, 32'h1);
    dq(OP_READ, 5'h02, 2'd1);
    $display("test reload done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_open();
    t_rows();
    t_prot();
    t_dbg();
    t_kill();
    t_sec();
    t_nv();
    summarize();
  end

  // Tests take well under a thousand cycles; this is twenty times more.
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule // tb_top

// ### inc/flash_prot_pkg.sv
package flash_prot_pkg;

  // Flash geometry: one protection bit per row, one register word per kind.
  localparam int NUM_ROWS = 32;
  localparam int ROW_W = 5;

  // Register byte offsets on the APB port.
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_RD_PROT = 32'h0000_0008;
  localparam logic [31:0] ADDR_WR_PROT = 32'h0000_000c;

  // Field positions in the control and status words.
  localparam int MODE_LSB = 0;
  localparam int DBG_EN_BIT = 4;
  localparam int SECURE_BIT = 8;
  localparam int ERASED_BIT = 12;
  localparam int LOADED_BIT = 13;

  typedef enum logic [1:0] {
    MODE_OPEN,
    MODE_PROTECTED,
    MODE_KILL
  } protMode_t;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_ERASE_ROW,
    OP_ERASE_ALL
  } flashOp_t;

  // Image of the settings kept in nonvolatile storage.
  typedef struct packed {
    protMode_t mode;
    logic debugEn;
    logic secure;
    logic [NUM_ROWS-1:0] rdProt;
    logic [NUM_ROWS-1:0] wrProt;
  } nvImage_t;

  typedef struct packed {
    logic valid;
    flashOp_t op;
    logic [ROW_W-1:0] row;
  } flashReq_t;

  // Reset values: open part, debug on, no lock, no row protection.
  localparam protMode_t RST_MODE = MODE_OPEN;
  localparam logic RST_DEBUG_EN = 1'b1;
  localparam logic RST_SECURE = 1'b0;
  localparam logic [NUM_ROWS-1:0] RST_ROW_PROT = 32'h0000_0000;

endpackage

// ### verilog/flash_debug_protection_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: Part comes up open: no chip protection, debug accesses all allowed.
// RL2: Open may go to protected; protected rejects every debug access.
// RL3: Protected returns to open only after a complete flash erase.
// RL4: Open may go to kill; kill blocks every debug access.
// RL5: Kill ignores erase requests from outside the chip.
// RL6: Kill is terminal; no transition leaves it.
// RL7: Each row has independent read-block and write-block protection.
// RL8: Firmware system calls may always read, write and erase flash; a call in the load cycle after reset is dropped ungranted.
// RL9: Debug starts enabled; only on-chip firmware can disable it.
// RL10: Host restores debug by full erase, unprotect, then new firmware.
// RL11: Device security permanently disables programming, debug and test ports.
// RL12: All protection settings live in nonvolatile state across resets.
module flash_debug_protection_ctrl
  import flash_prot_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire nvImage_t nvImage,
  output nvImage_t nvStore,
  output logic nvCommit,
  input wire flashReq_t dbgReq,
  output logic dbgGrant,
  output logic dbgDeny,
  input wire flashReq_t sysReq,
  output logic sysGrant,
  output flashReq_t flashCmd,
  input wire logic flashEraseAllDone,
  output logic debugPortEn,
  output logic testPortEn
);

  typedef struct packed {
    logic loaded;
    nvImage_t nv;
    logic erased;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic dbgGrant;
    logic dbgDeny;
    logic sysGrant;
    flashReq_t cmd;
    logic commit;
    logic portEn;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;

  function automatic logic addrHit(input logic [31:0] a);
    addrHit = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
      (a == ADDR_RD_PROT) || (a == ADDR_WR_PROT);
  endfunction

  // Mode moves only forward from open, except the erased return path.
  function automatic logic modeOk(input protMode_t cur,
                                  input logic [1:0] req,
                                  input logic erased);
    modeOk = 1'b0;
    if (req == cur) begin
      modeOk = 1'b1;
    end else if (cur == MODE_OPEN) begin
      modeOk = (req == MODE_PROTECTED) || (req == MODE_KILL); // [RL2] [RL4]
    end else if (cur == MODE_PROTECTED) begin
      modeOk = (req == MODE_OPEN) && erased; // [RL3]
    end
  endfunction

  function automatic logic [31:0] regRead(input logic [31:0] a,
                                          input ctrl_t s);
    regRead = 32'h0000_0000;
    if (a == ADDR_CTRL || a == ADDR_STATUS) begin
      regRead[MODE_LSB +: 2] = s.nv.mode;
      regRead[DBG_EN_BIT] = s.nv.debugEn;
      regRead[SECURE_BIT] = s.nv.secure;
    end
    if (a == ADDR_STATUS) begin
      regRead[ERASED_BIT] = s.erased;
      regRead[LOADED_BIT] = s.loaded;
    end
    if (a == ADDR_RD_PROT) begin
      regRead = s.nv.rdProt;
    end
    if (a == ADDR_WR_PROT) begin
      regRead = s.nv.wrProt;
    end
  endfunction

  // Debug access check for open mode with debug enabled.
  function automatic logic rowOk(input nvImage_t n, input flashReq_t r);
    case (r.op)
      OP_READ: rowOk = !n.rdProt[r.row]; // [RL7]
      OP_WRITE: rowOk = !n.wrProt[r.row]; // [RL7]
      OP_ERASE_ROW: rowOk = !n.wrProt[r.row]; // [RL7]
      OP_ERASE_ALL: rowOk = 1'b1;
      default: rowOk = 1'b0;
    endcase
  endfunction

  logic setupPhase;
  logic accessWr;
  logic dbgIsErase;

  always_comb begin
    setupPhase = psel && !penable;
    accessWr = psel && penable && st.ready && pwrite;
    dbgIsErase = (dbgReq.op == OP_ERASE_ROW) || (dbgReq.op == OP_ERASE_ALL);
    next_st = st;
    next_st.dbgGrant = 1'b0;
    next_st.dbgDeny = 1'b0;
    next_st.sysGrant = 1'b0;
    next_st.cmd = '0;
    next_st.commit = 1'b0;

    // The settings are fetched once after reset, so the reset values only
    // stand for the single cycle before the stored image is applied.
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.nv = nvImage; // [RL12]
    end else begin
      // APB: the answer is prepared in the setup cycle, so the access
      // phase completes in one cycle; a setup in the load cycle gets no answer.
      next_st.ready = setupPhase;
      if (setupPhase) begin
        next_st.rdata = pwrite ? 32'h0000_0000 : regRead(paddr, st);
        next_st.slvErr = !addrHit(paddr) ||
          (pwrite && paddr == ADDR_CTRL &&
           !modeOk(st.nv.mode, pwdata[MODE_LSB +: 2], st.erased));
      end
      if (accessWr && paddr == ADDR_CTRL) begin
        if (modeOk(st.nv.mode, pwdata[MODE_LSB +: 2], st.erased)) begin
          next_st.nv.mode = protMode_t'(pwdata[MODE_LSB +: 2]); // [RL6]
        end
        next_st.nv.debugEn = pwdata[DBG_EN_BIT]; // [RL9]
        // A control write only ever sets the lock; only reset and the stored-image reload can clear it.
        next_st.nv.secure = st.nv.secure | pwdata[SECURE_BIT]; // [RL11]
      end
      if (accessWr && paddr == ADDR_RD_PROT) begin
        next_st.nv.rdProt = pwdata; // [RL7]
      end
      if (accessWr && paddr == ADDR_WR_PROT) begin
        next_st.nv.wrProt = pwdata; // [RL7]
      end

      // System calls own the flash port first and are granted in every cycle after the load cycle.
      if (sysReq.valid) begin
        next_st.sysGrant = 1'b1; // [RL8]
        next_st.cmd = sysReq; // [RL8]
      end

      if (dbgReq.valid) begin
        if (st.nv.secure) begin
          // Port is dead: no answer of any kind.
          next_st.dbgDeny = 1'b0; // [RL11]
        end else if (st.nv.mode == MODE_KILL && dbgIsErase) begin
          // Silently dropped so a power cut can never half erase the part.
          next_st.dbgDeny = 1'b0; // [RL5]
        end else if (st.nv.mode == MODE_OPEN && st.nv.debugEn &&
                     !sysReq.valid && rowOk(st.nv, dbgReq)) begin
          next_st.dbgGrant = 1'b1; // [RL1]
          next_st.cmd = dbgReq;
        end else begin
          next_st.dbgDeny = 1'b1; // [RL2] [RL4] [RL9]
        end
      end

      // Program operations dirty the array; a completed full erase marks
      // it clean, and the completion wins over a write in the same cycle.
      if (next_st.cmd.valid && next_st.cmd.op == OP_WRITE) begin
        next_st.erased = 1'b0;
      end
      if (flashEraseAllDone) begin
        next_st.erased = 1'b1; // [RL3]
      end
      next_st.commit = (next_st.nv != st.nv); // [RL12]
    end
    next_st.portEn = !next_st.nv.secure; // [RL11]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.loaded <= 1'b0;
      st.nv.mode <= RST_MODE; // [RL1]
      st.nv.debugEn <= RST_DEBUG_EN; // [RL9]
      st.nv.secure <= RST_SECURE;
      st.nv.rdProt <= RST_ROW_PROT;
      st.nv.wrProt <= RST_ROW_PROT;
      st.erased <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.ready <= 1'b0;
      st.slvErr <= 1'b0;
      st.dbgGrant <= 1'b0;
      st.dbgDeny <= 1'b0;
      st.sysGrant <= 1'b0;
      st.cmd <= '0;
      st.commit <= 1'b0;
      st.portEn <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slvErr;
  assign nvStore = st.nv;
  assign nvCommit = st.commit;
  assign dbgGrant = st.dbgGrant;
  assign dbgDeny = st.dbgDeny;
  assign sysGrant = st.sysGrant;
  assign flashCmd = st.cmd;
  assign debugPortEn = st.portEn;
  assign testPortEn = st.portEn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_open_start: assert property ( // [RL1]
    !st.loaded |-> st.nv.mode == MODE_OPEN && st.nv.debugEn)
    else $error("Block did not start in open mode with debug on.");

  chk_open_grants: assert property ( // [RL1]
    st.loaded && dbgReq.valid && !sysReq.valid &&
    st.nv.mode == MODE_OPEN && st.nv.debugEn && !st.nv.secure &&
    dbgReq.op == OP_ERASE_ALL |=> dbgGrant && flashCmd == $past(dbgReq))
    else $error("Open mode refused an allowed debug access.");

  chk_prot_blocks: assert property ( // [RL2]
    st.loaded && dbgReq.valid && st.nv.mode == MODE_PROTECTED
    |=> !dbgGrant && (dbgDeny || $past(st.nv.secure)))
    else $error("Protected mode let a debug access through.");

  chk_reopen_erased: assert property ( // [RL3]
    st.loaded && st.nv.mode == MODE_PROTECTED && !st.erased
    |=> st.nv.mode != MODE_OPEN)
    else $error("Protected mode reopened without a full erase.");

  chk_kill_blocks: assert property ( // [RL4]
    st.loaded && dbgReq.valid && st.nv.mode == MODE_KILL |=> !dbgGrant)
    else $error("Kill mode let a debug access through.");

  chk_kill_erase: assert property ( // [RL5]
    st.loaded && dbgReq.valid && st.nv.mode == MODE_KILL &&
    (dbgReq.op == OP_ERASE_ROW || dbgReq.op == OP_ERASE_ALL)
    |=> !dbgGrant && !dbgDeny && flashCmd.op != OP_ERASE_ALL ||
        $past(sysReq.valid))
    else $error("Kill mode acted on an outside erase request.");

  chk_kill_stays: assert property ( // [RL6]
    st.loaded && st.nv.mode == MODE_KILL |=> st.nv.mode == MODE_KILL [*3])
    else $error("Kill mode was left.");

  chk_row_read: assert property ( // [RL7]
    st.loaded && dbgReq.valid && dbgReq.op == OP_READ &&
    st.nv.rdProt[dbgReq.row] |=> !dbgGrant)
    else $error("Read of a read-protected row was granted.");

  chk_sys_always: assert property ( // [RL8]
    st.loaded && sysReq.valid
    |=> sysGrant && flashCmd == $past(sysReq))
    else $error("A system call flash operation was not granted.");

  chk_dbg_disable: assert property ( // [RL9]
    $past(st.loaded) && $fell(st.nv.debugEn)
    |-> $past(psel && penable && pwrite && paddr == ADDR_CTRL))
    else $error("Debug was disabled without a firmware write.");

  chk_secure_off: assert property ( // [RL11]
    st.loaded && st.nv.secure
    |=> st.nv.secure && !debugPortEn && !testPortEn && !dbgGrant)
    else $error("Secured part reopened an interface.");

  chk_nv_restore: assert property ( // [RL12]
    !st.loaded && reset_n
    |=> st.loaded && st.nv == $past(nvImage) ##1 st.loaded)
    else $error("Stored settings were not applied after reset.");

  chk_answer_excl: assert property ( // [RL2]
    !(dbgGrant && dbgDeny))
    else $error("Debug request was granted and denied at once.");

  chk_prot_no_cmd: assert property ( // [RL2]
    st.loaded && dbgReq.valid && !sysReq.valid &&
    st.nv.mode == MODE_PROTECTED |=> !flashCmd.valid)
    else $error("Protected mode issued a debug flash command.");

  chk_kill_no_cmd: assert property ( // [RL5]
    st.loaded && dbgReq.valid && !sysReq.valid &&
    st.nv.mode == MODE_KILL |=> !flashCmd.valid)
    else $error("Kill mode issued a debug flash command.");

  chk_row_write: assert property ( // [RL7]
    st.loaded && dbgReq.valid && dbgReq.op != OP_READ &&
    dbgReq.op != OP_ERASE_ALL && st.nv.wrProt[dbgReq.row] |=> !dbgGrant)
    else $error("Write or erase of a write-protected row was granted.");

  chk_kill_entry: assert property ( // [RL4]
    st.loaded && st.nv.mode == MODE_PROTECTED |=> st.nv.mode != MODE_KILL)
    else $error("Kill mode was entered from protected mode.");

  chk_port_enable: assert property ( // [RL11]
    st.loaded
    |-> debugPortEn == !st.nv.secure && testPortEn == !st.nv.secure)
    else $error("Port enables disagree with the security lock.");

  chk_commit_pulse: assert property ( // [RL12]
    st.loaded && $past(st.loaded) && $changed(st.nv)
    |-> nvCommit)
    else $error("Settings changed without a store pulse.");

  chk_dbg_off_deny: assert property ( // [RL9]
    st.loaded && dbgReq.valid && !st.nv.debugEn
    |=> !dbgGrant)
    else $error("Debug access was granted with debug disabled.");

  chk_reopen_source: assert property ( // [RL3]
    st.loaded && $past(st.loaded) && $changed(st.nv.mode) &&
    st.nv.mode == MODE_OPEN
    |-> $past(st.nv.mode) == MODE_PROTECTED && $past(st.erased))
    else $error("Open mode was reached other than by an erased return.");

  chk_grant_open: assert property ( // [RL1]
    dbgGrant
    |-> $past(st.nv.mode) == MODE_OPEN && $past(st.nv.debugEn))
    else $error("Debug grant given outside open mode with debug on.");

  chk_erase_flag: assert property ( // [RL3]
    st.loaded && flashEraseAllDone |=> st.erased)
    else $error("Completed full erase was not recorded.");

  chk_lock_sets: assert property ( // [RL11]
    st.loaded && psel && penable && pready && pwrite &&
    paddr == ADDR_CTRL && pwdata[SECURE_BIT] |=> st.nv.secure)
    else $error("Security lock write did not take effect.");

endmodule // flash_debug_protection_ctrl
